// ---- bench/acc_afe_model.sv ----
// analog input sources behind the channel multiplexer
`timescale 1ns/1ns
`default_nettype none
module acc_afe_model
  import acc_pkg::*;
#(
  parameter logic [7:0] BASE = 8'h5A
)
(
  // clock
  input  wire logic              clk_i,
  // request and returned value
  input  wire acc_pkg::acc_afe_t afe_i,
  output logic [7:0]             data_o
);
  logic [7:0] last = 8'hA5;
  // steady while sampling: no other port traffic disturbs it
  // outside a conversion the value means nothing, so it churns
  always @(posedge clk_i)
    last <= afe_i.sample ? data_o : ~last;
  assign data_o = afe_i.sample ? BASE + {afe_i.channel, afe_i.channel} : last;
endmodule // acc_afe_model
`default_nettype wire

// ---- bench/acc_assertions.sv ----
// assertion checker for the converter control block
`timescale 1ns/1ns
`default_nettype none
module acc_checker
  import acc_pkg::*;
(
  // watched ports
  input wire logic              clk_i,
  input wire logic              rst_b_i,
  input wire logic              low_power_i,
  input wire acc_pkg::acc_afe_t afe_o,
  input wire logic              conv_done_irq_o,
  input wire logic              s_arvalid_i,
  input wire logic              s_arready_o,
  input wire logic [31:0]       s_rdata_o,
  input wire logic              s_rvalid_o,
  input wire logic              s_rready_i,
  input wire logic              s_bvalid_o,
  input wire logic              s_bready_i
);
  logic [10:0] run;
  // cycles spent converting, zeroed when idle
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i) run <= 11'h000;
    else run <= afe_o.sample ? run + 11'h001 : 11'h000;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // interrupt, timing, low-power and bus behaviour
  chk_irq_single: assert property (conv_done_irq_o |=> !conv_done_irq_o)
    else $error("done pulse wider than one cycle");
  chk_done_at_end: assert property (conv_done_irq_o |-> !afe_o.sample && $past(afe_o.sample))
    else $error("done pulse not at end of conversion");
  // an abort under low power may end a run at any count
  chk_conv_length: assert property ($fell(afe_o.sample) && !low_power_i |->
    run == ACC_T0 || run == ACC_T2 || run == ACC_T3 || run == ACC_T4 || run == ACC_T5
    || run == ACC_T6)
    else $error("conversion length wrong");
  chk_lp_quiet: assert property (low_power_i && $past(low_power_i) |->
    !afe_o.sample && !afe_o.ref_on)
    else $error("front end active in low power");
  chk_lp_no_start: assert property ($rose(afe_o.sample) |-> !low_power_i)
    else $error("conversion started in low power");
  chk_rdata_byte: assert property (s_rvalid_o |-> s_rdata_o[31:8] == 24'h000000)
    else $error("read data above byte lane");
  chk_read_lat: assert property (s_arvalid_i && s_arready_o |-> ##2 s_rvalid_o)
    else $error("read answer late");
  chk_rvalid_drop: assert property (s_rvalid_o && s_rready_i |=> !s_rvalid_o)
    else $error("read data not released");
  chk_bvalid_drop: assert property (s_bvalid_o && s_bready_i |=> !s_bvalid_o)
    else $error("write response not released");
  // main scenarios
  cov_done: cover property (conv_done_irq_o);
  cov_abort: cover property ($fell(afe_o.sample) && low_power_i);
  cov_read: cover property (s_rvalid_o && s_rready_i);
endmodule // acc_checker
bind acc_top acc_checker acc_checker_inst (.clk_i, .rst_b_i, .low_power_i, .afe_o,
  .conv_done_irq_o, .s_arvalid_i, .s_arready_o, .s_rdata_o, .s_rvalid_o, .s_rready_i,
  .s_bvalid_o, .s_bready_i);
`default_nettype wire

// ---- bench/adc_conversion_control_tb_top.sv ----
// self-checking testbench for the converter control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module adc_conversion_control_tb_top;
  import acc_pkg::*;
  localparam logic [7:0] BASE = 8'h5A;
  // design ports
  logic clk_i, rst_b_i, ce_i, low_power_i, conv_done_irq_o, irq_o;
  acc_afe_t afe_o;
  logic [7:0] afe_data_i, s_awaddr_i, s_araddr_i;
  logic [31:0] s_wdata_i, s_rdata_o, rdat;
  logic [3:0] s_wstrb_i;
  logic [1:0] s_bresp_o, s_rresp_o, resp;
  logic s_awvalid_i, s_awready_o, s_wvalid_i, s_wready_o, s_bvalid_o, s_bready_i;
  logic s_arvalid_i, s_arready_o, s_rvalid_o, s_rready_i;
  int n_fail = 0, checks_done = 0, cyc = 0;
  logic [10:0] run_len = 11'h000;
  acc_top acc_top_inst (.clk_i, .rst_b_i, .ce_i, .low_power_i, .afe_o, .afe_data_i,
    .conv_done_irq_o, .irq_o, .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wdata_i,
    .s_wstrb_i, .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i,
    .s_araddr_i, .s_arvalid_i, .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o,
    .s_rready_i);
  acc_afe_model #(.BASE(BASE)) acc_afe_model_inst (.clk_i, .afe_i(afe_o), .data_o(afe_data_i));
  function automatic logic [31:0] ana(input logic [3:0] c);
    ana = {24'h000000, BASE + {c, c}};
  endfunction
  task automatic close_out();
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // readies sampled mid-cycle, so the edge that takes them is not raced
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    s_awaddr_i <= a; s_wdata_i <= d; s_awvalid_i <= 1'b1; s_wvalid_i <= 1'b1;
    s_bready_i <= 1'b1; hb = 1'b0;
    while (!hb)
    begin
      @(negedge clk_i);
      ha = s_awvalid_i && s_awready_o; hw = s_wvalid_i && s_wready_o; hb = s_bvalid_o;
      resp = s_bresp_o;
      @(posedge clk_i);
      if (ha) s_awvalid_i <= 1'b0;
      if (hw) s_wvalid_i <= 1'b0;
    end
    s_bready_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ha, hr;
    s_araddr_i <= a; s_arvalid_i <= 1'b1; s_rready_i <= 1'b1; hr = 1'b0;
    while (!hr)
    begin
      @(negedge clk_i);
      ha = s_arvalid_i && s_arready_o; hr = s_rvalid_o; rdat = s_rdata_o; resp = s_rresp_o;
      @(posedge clk_i);
      if (ha) s_arvalid_i <= 1'b0;
    end
    s_rready_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    `CHK(rdat & m, e)
  endtask
  task automatic irq_is(input logic e);
    @(negedge clk_i);
    `CHK(irq_o, e)
    @(posedge clk_i);
  endtask
  task automatic start(input logic [3:0] ch, input logic [2:0] code);
    wr(ACC_OFS_CTRL_ONE, {28'h0000002, ch});
    wr(ACC_OFS_CTRL_TWO, {24'h000000, 3'b001, 1'b1, code, 1'b0});
    wr(ACC_OFS_IRQ_CLR, 32'h00000003);
    @(negedge clk_i);
    run_len = 11'h000;
    @(posedge clk_i);
    wr(ACC_OFS_CTRL_ONE, {28'h000000A, ch});
  endtask
  task automatic wait_done(input logic [10:0] n);
    int k;
    k = 0;
    do begin @(negedge clk_i); k++; end while (conv_done_irq_o !== 1'b1 && k < 2000);
    `CHK(run_len, n)
    `CHK(irq_o, 1'b1)
    @(posedge clk_i);
  endtask
  task automatic t_regs();
    rdc(ACC_OFS_CTRL_ONE, 32'hFF, {24'h0, ACC_RST_CTRL_ONE});
    rdc(ACC_OFS_CTRL_TWO, 32'hFF, {24'h0, ACC_RST_CTRL_TWO});
    rdc(ACC_OFS_STATUS, 32'h30, 32'h00);
    rd(8'h1C);
    `CHK(resp, 2'b10)
    `CHK(rdat, 32'h00000000)
    wr(ACC_OFS_IRQ_EN, 32'h00000001);
    `CHK(resp, 2'b00)
    wr(8'h1C, 32'h00000000);
    `CHK(resp, 2'b10)
  endtask
  task automatic t_convert();
    start(4'h3, 3'h4);
    rdc(ACC_OFS_STATUS, 32'h30, 32'h10);
    rdc(ACC_OFS_CTRL_ONE, 32'hFF, 32'h23);
    wait_done(ACC_T4);
    rdc(ACC_OFS_STATUS, 32'h30, 32'h20);
    rdc(ACC_OFS_RESULT, 32'hFF, ana(4'h3));
    rdc(ACC_OFS_STATUS, 32'h30, 32'h00);
    wr(ACC_OFS_IRQ_EN, 32'h00000000);
    irq_is(1'b0);
    wr(ACC_OFS_IRQ_EN, 32'h00000001);
    irq_is(1'b1);
    wr(ACC_OFS_IRQ_CLR, 32'h00000001);
    irq_is(1'b0);
  endtask
  task automatic t_codes();
    logic [10:0] n [6] = '{ACC_T0, ACC_T2, ACC_T3, ACC_T5, ACC_T6, ACC_T6};
    logic [2:0]  c [6] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
    for (int i = 0; i < 6; i++)
    begin
      start(4'h1, c[i]);
      wait_done(n[i]);
      rdc(ACC_OFS_RESULT, 32'hFF, ana(4'h1));
    end
  endtask
  task automatic t_restart();
    start(4'h5, 3'h4);
    wait_done(ACC_T4);
    start(4'h6, 3'h4);
    rdc(ACC_OFS_STATUS, 32'h30, 32'h10);
    rdc(ACC_OFS_RESULT, 32'hFF, ana(4'h5));
    wait_done(ACC_T4);
    rdc(ACC_OFS_RESULT, 32'hFF, ana(4'h6));
  endtask
  task automatic t_lowpower();
    start(4'h2, 3'h4);
    repeat (20) @(posedge clk_i);
    low_power_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rdc(ACC_OFS_STATUS, 32'h30, 32'h00);
    rdc(ACC_OFS_CTRL_ONE, 32'hFF, {24'h0, ACC_RST_CTRL_ONE});
    rdc(ACC_OFS_CTRL_TWO, 32'hFF, {24'h0, ACC_RST_CTRL_TWO});
    rdc(ACC_OFS_RESULT, 32'hFF, 32'h00);
    rdc(ACC_OFS_IRQ_STAT, 32'h02, 32'h02);
    wr(ACC_OFS_CTRL_ONE, 32'h000000A3);
    rdc(ACC_OFS_CTRL_ONE, 32'hFF, {24'h0, ACC_RST_CTRL_ONE});
    wr(ACC_OFS_CTRL_TWO, 32'h0000002E);
    rdc(ACC_OFS_CTRL_TWO, 32'hFF, {24'h0, ACC_RST_CTRL_TWO});
    `CHK(afe_o.ref_on, 1'b0)
    low_power_i <= 1'b0;
    @(negedge clk_i);
    run_len = 11'h000;
    repeat (400) @(posedge clk_i);
    `CHK(run_len, 11'h000)
    rdc(ACC_OFS_STATUS, 32'h30, 32'h00);
    start(4'h4, 3'h4);
    wait_done(ACC_T4);
    rdc(ACC_OFS_RESULT, 32'hFF, ana(4'h4));
  endtask
  // clock and run watchdog
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (afe_o.sample === 1'b1) run_len <= run_len + 11'h001;
    if (cyc == 20000)
    begin
      n_fail++;
      close_out();
    end
  end
  // main sequence
  initial
  begin
    rst_b_i = 1'b0; ce_i = 1'b1; low_power_i = 1'b0; s_wstrb_i = 4'hF;
    s_awaddr_i = 8'h00; s_awvalid_i = 1'b0; s_wdata_i = 32'h0; s_wvalid_i = 1'b0;
    s_bready_i = 1'b0; s_araddr_i = 8'h00; s_arvalid_i = 1'b0; s_rready_i = 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    t_regs();
    t_convert();
    t_codes();
    t_restart();
    t_lowpower();
    close_out();
  end
endmodule // adc_conversion_control_tb_top
`default_nettype wire

// ---- include/acc_pkg.sv ----
// package for the converter control block: offsets, fields, reset values, counts
//
// Overview of operation
// R1 - writing one to conv_start begins converting the channel in channel_select
// R2 - completion stores result, sets conv_end_flag and fires interrupt together
// R3 - conv_start clears itself once the conversion has begun
// R4 - software must not set conv_start again while a conversion runs
// R5 - reading the conversion result clears conv_end_flag
// R6 - a new start clears conv_end_flag but old result stays until completion
// R7 - software configures channel and input, then time and reference, then starts
// R8 - conversion lasts exactly the time picked by the time select field
// R9 - entering stop or slow aborts conversion and resets both control registers
// R10 - abort by low-power mode clears earlier results
// R11 - no automatic restart after low-power mode; software restarts
// R12 - in stop or slow the reference ladder is disconnected
// R13 - each conversion yields an 8-bit unsigned value
// R14 - software avoids port accesses during a conversion
// R15 - busy flag sets at start, clears at finish and on low-power entry
// R16 - software reads status before result since result read clears the flag
// R17 - in low-power modes both control registers stay initial and ignore writes
// R18 - conversion done interrupt request is one clock pulse with flag set
package acc_pkg;
  // register byte offsets
  localparam logic [7:0] ACC_OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] ACC_OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] ACC_OFS_RESULT   = 8'h08;
  localparam logic [7:0] ACC_OFS_STATUS   = 8'h0C;
  localparam logic [7:0] ACC_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] ACC_OFS_IRQ_EN   = 8'h14;
  localparam logic [7:0] ACC_OFS_IRQ_CLR  = 8'h18;
  // control one fields
  localparam int ACC_BIT_START = 7;
  localparam int ACC_BIT_AIND  = 4;
  localparam int ACC_SEL_LSB   = 0;
  // control two fields
  localparam int ACC_BIT_REF   = 5;
  localparam int ACC_TIME_LSB  = 1;
  // status fields
  localparam int ACC_BIT_EOC   = 5;
  localparam int ACC_BIT_BUSY  = 4;
  // reset values (fixed bits: one bit5=1/bit6=0, two bit4=1/bit0=0)
  localparam logic [7:0] ACC_RST_CTRL_ONE = 8'h3F;
  localparam logic [7:0] ACC_RST_CTRL_TWO = 8'h10;
  localparam logic [7:0] ACC_CTRL_ONE_WMASK = 8'h9F;
  localparam logic [7:0] ACC_CTRL_TWO_WMASK = 8'h2E;
  localparam logic [7:0] ACC_CTRL_ONE_FIXED = 8'h20;
  localparam logic [7:0] ACC_CTRL_TWO_FIXED = 8'h10;
  // conversion times in fc cycles, per time select code
  localparam logic [10:0] ACC_T0 = 11'd39;
  localparam logic [10:0] ACC_T2 = 11'd78;
  localparam logic [10:0] ACC_T3 = 11'd156;
  localparam logic [10:0] ACC_T4 = 11'd312;
  localparam logic [10:0] ACC_T5 = 11'd624;
  localparam logic [10:0] ACC_T6 = 11'd1248;
  // interrupt status bit positions
  localparam int ACC_IRQ_DONE = 0;
  localparam int ACC_IRQ_ABORT = 1;
  // sequencer states
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b01,
    ACC_CONV = 2'b10
  } acc_state_t;
  // request to the analog front end
  typedef struct packed {
    logic       sample;
    logic [3:0] channel;
    logic       ref_on;
    logic       ain_off;
  } acc_afe_t;
  // time select to cycle count
  function automatic logic [10:0] acc_conv_cycles(input logic [2:0] sel);
    case (sel)
      3'h0:    acc_conv_cycles = ACC_T0;
      3'h2:    acc_conv_cycles = ACC_T2;
      3'h3:    acc_conv_cycles = ACC_T3;
      3'h4:    acc_conv_cycles = ACC_T4;
      3'h5:    acc_conv_cycles = ACC_T5;
      3'h6:    acc_conv_cycles = ACC_T6;
      default: acc_conv_cycles = ACC_T6;
    endcase
  endfunction
endpackage

// ---- rtl/acc_timer.sv ----
// conversion time counter
`timescale 1ns/1ns
`default_nettype none
module acc_timer
  import acc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        ce_i,
  // control
  input  wire logic        load_i,
  input  wire logic        abort_i,
  input  wire logic [10:0] cycles_i,
  // status
  output logic             done_o
);
  logic [10:0] count;
  // done on the last of the loaded cycles
  assign done_o = (count == 11'd1);
  // count down to zero; abort has priority
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      count <= 11'd0;
    else if (ce_i)
    begin
      if (abort_i)
        count <= 11'd0;
      else if (load_i)
        count <= cycles_i; // see R8
      else if (count != 11'd0)
        count <= count - 11'd1;
    end
  end
endmodule // acc_timer
`default_nettype wire

// ---- rtl/acc_top.sv ----
// converter control block with axi4-lite register slave
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module acc_top
  import acc_pkg::*;
(
  // clock, reset, enable
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         ce_i,
  // low-power mode request, from the same clock domain
  input  wire logic         low_power_i,
  // analog front end
  output acc_pkg::acc_afe_t afe_o,
  input  wire logic [7:0]   afe_data_i,
  // interrupts
  output logic              conv_done_irq_o,
  output logic              irq_o,
  // axi4-lite write address
  input  wire logic [7:0]   s_awaddr_i,
  input  wire logic         s_awvalid_i,
  output logic              s_awready_o,
  // axi4-lite write data
  input  wire logic [31:0]  s_wdata_i,
  input  wire logic [3:0]   s_wstrb_i,
  input  wire logic         s_wvalid_i,
  output logic              s_wready_o,
  // axi4-lite write response
  output logic [1:0]        s_bresp_o,
  output logic              s_bvalid_o,
  input  wire logic         s_bready_i,
  // axi4-lite read address
  input  wire logic [7:0]   s_araddr_i,
  input  wire logic         s_arvalid_i,
  output logic              s_arready_o,
  // axi4-lite read data
  output logic [31:0]       s_rdata_o,
  output logic [1:0]        s_rresp_o,
  output logic              s_rvalid_o,
  input  wire logic         s_rready_i
);
  import acc_pkg::*;

  acc_state_t  state;
  acc_state_t  next_state;
  logic [7:0]  converter_ctrl_one;
  logic [7:0]  converter_ctrl_two;
  logic [7:0]  conversion_result;
  logic        conv_end_flag;
  logic        conv_busy_flag;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_en;
  logic        lp_q;

  // write and read channel holding
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        ar_held;
  logic [7:0]  ar_addr;

  // write address and data may arrive in either order
  assign s_awready_o = ce_i && !aw_held && !s_bvalid_o;
  assign s_wready_o  = ce_i && !w_held && !s_bvalid_o;
  wire         aw_take = s_awvalid_i && s_awready_o;
  wire         w_take  = s_wvalid_i && s_wready_o;
  wire         aw_have = aw_held || aw_take;
  wire         w_have  = w_held || w_take;
  wire [7:0]   wr_addr = aw_held ? aw_addr : s_awaddr_i;
  wire [31:0]  wr_data = w_held ? w_data : s_wdata_i;
  wire         wr_lane = w_held ? w_strb[0] : s_wstrb_i[0];
  wire         wr_fire = ce_i && aw_have && w_have && !s_bvalid_o;
  wire         wr_ok   = wr_fire && wr_lane;

  // write address decode; read-only registers still answer okay
  wire         ws_one  = (wr_addr == ACC_OFS_CTRL_ONE);
  wire         ws_two  = (wr_addr == ACC_OFS_CTRL_TWO);
  wire         ws_res  = (wr_addr == ACC_OFS_RESULT);
  wire         ws_stat = (wr_addr == ACC_OFS_STATUS);
  wire         ws_ist  = (wr_addr == ACC_OFS_IRQ_STAT);
  wire         ws_ien  = (wr_addr == ACC_OFS_IRQ_EN);
  wire         ws_iclr = (wr_addr == ACC_OFS_IRQ_CLR);
  wire         wr_map  = ws_one || ws_two || ws_res || ws_stat
                      || ws_ist || ws_ien || ws_iclr;

  // register write strobes; low-power entry locks the control pair
  // the lock follows the level, so a write racing the entry is lost too
  wire         lp_lock = low_power_i; // see R17
  wire         wr_one  = wr_ok && !lp_lock && ws_one;
  wire         wr_two  = wr_ok && !lp_lock && ws_two;
  wire         wr_ien  = wr_ok && ws_ien;
  wire         wr_iclr = wr_ok && ws_iclr;

  // read side
  assign s_arready_o = ce_i && !ar_held && !s_rvalid_o;
  wire         ar_take = s_arvalid_i && s_arready_o;
  // read decode on the held address, so a new request cannot race the answer
  wire         rs_one  = (ar_addr == ACC_OFS_CTRL_ONE);
  wire         rs_two  = (ar_addr == ACC_OFS_CTRL_TWO);
  wire         rs_res  = (ar_addr == ACC_OFS_RESULT);
  wire         rs_stat = (ar_addr == ACC_OFS_STATUS);
  wire         rs_ist  = (ar_addr == ACC_OFS_IRQ_STAT);
  wire         rs_ien  = (ar_addr == ACC_OFS_IRQ_EN);
  wire         rs_iclr = (ar_addr == ACC_OFS_IRQ_CLR); // write-only, reads zero
  wire         rd_map  = rs_one || rs_two || rs_res || rs_stat
                      || rs_ist || rs_ien || rs_iclr;
  wire         rd_fire = ce_i && ar_held && !s_rvalid_o;
  // only a result read clears the end flag, a status read leaves it alone
  wire         rd_res  = rd_fire && rs_res; // see R5, R16

  // sequencer controls
  wire         start_req = wr_one && wr_data[ACC_BIT_START] && (state == ACC_IDLE); // see R1
  // only the first low-power cycle is an entry; a held level is no new abort
  wire         lp_enter  = low_power_i && !lp_q;
  wire         timer_done;
  // a completion on the entry cycle is lost to the abort
  wire         conv_fin  = (state == ACC_CONV) && timer_done && !low_power_i;
  wire         abort     = (state == ACC_CONV) && lp_enter; // see R9
  wire [2:0]   time_sel  = converter_ctrl_two[ACC_TIME_LSB +: 3];

  // next state
  // a start while converting is not decoded, so software must wait for the flag
  always_comb
  begin
    next_state = state;
    case (state)
      ACC_IDLE: if (start_req) next_state = ACC_CONV;
      ACC_CONV: if (conv_fin || low_power_i) next_state = ACC_IDLE; // see R11
      default:  next_state = ACC_IDLE;
    endcase
  end

  // the timer loads on the start edge and is zeroed by low power
  acc_timer acc_timer_inst (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .ce_i     (ce_i),
    .load_i   (start_req),
    .abort_i  (low_power_i),
    .cycles_i (acc_conv_cycles(time_sel)),
    .done_o   (timer_done)
  );

  // state and low-power edge
  // lp_q keeps the last level so that the entry edge can be found
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state <= ACC_IDLE;
      lp_q  <= 1'b0;
    end
    else if (ce_i)
    begin
      state <= next_state;
      lp_q  <= low_power_i;
    end
  end

  // control one; start bit never stored, so it reads back cleared
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      converter_ctrl_one <= ACC_RST_CTRL_ONE;
    else if (ce_i)
    begin
      if (low_power_i)
        converter_ctrl_one <= ACC_RST_CTRL_ONE; // see R9
      else if (wr_one)
        converter_ctrl_one <= (wr_data[7:0] & ACC_CTRL_ONE_WMASK & ~8'h80)
                            | ACC_CTRL_ONE_FIXED; // see R3
    end
  end

  // control two
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      converter_ctrl_two <= ACC_RST_CTRL_TWO;
    else if (ce_i)
    begin
      if (low_power_i)
        converter_ctrl_two <= ACC_RST_CTRL_TWO; // see R9
      else if (wr_two)
        converter_ctrl_two <= (wr_data[7:0] & ACC_CTRL_TWO_WMASK) | ACC_CTRL_TWO_FIXED;
    end
  end

  // result and flags; completion beats a same-cycle result read
  // a run cut by low power leaves no result, the front end was mid-sample
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      conversion_result <= 8'h00;
      conv_end_flag     <= 1'b0;
      conv_busy_flag    <= 1'b0;
    end
    else if (ce_i)
    begin
      if (low_power_i)
      begin
        if (lp_enter)
          conversion_result <= 8'h00; // see R10
        conv_end_flag  <= 1'b0;
        conv_busy_flag <= 1'b0; // see R15
      end
      else if (conv_fin)
      begin
        conversion_result <= afe_data_i; // see R2, R13
        conv_end_flag     <= 1'b1;
        conv_busy_flag    <= 1'b0; // see R15
      end
      else if (start_req)
      begin
        conv_end_flag  <= 1'b0; // see R6
        conv_busy_flag <= 1'b1; // see R15
      end
      else if (rd_res)
        conv_end_flag <= 1'b0; // see R5
    end
  end

  // one-cycle request pulse, registered with the flag
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      conv_done_irq_o <= 1'b0;
    else if (ce_i)
      conv_done_irq_o <= conv_fin; // see R18
  end

  // sticky interrupt status; set wins over clear
  wire [1:0] irq_set = {abort, conv_fin};
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      irq_stat <= 2'b00;
      irq_en   <= 2'b00;
    end
    else if (ce_i)
    begin
      irq_stat <= (irq_stat & ~(wr_iclr ? wr_data[1:0] : 2'b00)) | irq_set;
      if (wr_ien)
        irq_en <= wr_data[1:0];
    end
  end
  assign irq_o = |(irq_stat & irq_en);

  // analog front end drive; ladder off in low power
  // sample stands for the whole run; the ladder follows it unless forced on
  assign afe_o.sample  = (state == ACC_CONV);
  assign afe_o.channel = converter_ctrl_one[ACC_SEL_LSB +: 4];
  assign afe_o.ref_on  = !low_power_i
                       && (converter_ctrl_two[ACC_BIT_REF] || (state == ACC_CONV)); // see R12
  assign afe_o.ain_off = converter_ctrl_one[ACC_BIT_AIND];

  // read mux
  // unused status and control bits read as zero rather than floating
  wire [7:0] status_byte = {2'b00, conv_end_flag, conv_busy_flag, 4'h0};
  wire [31:0] rd_word =
      rs_one  ? {24'h0, converter_ctrl_one} :
      rs_two  ? {24'h0, 2'b00, converter_ctrl_two[5:0]} :
      rs_res  ? {24'h0, conversion_result} :
      rs_stat ? {24'h0, status_byte} :
      rs_ist  ? {30'h0, irq_stat} :
      rs_ien  ? {30'h0, irq_en} : 32'h0;

  // write channel bookkeeping and response
  // both readies drop while a response waits, so one write is in flight
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      aw_held    <= 1'b0;
      w_held     <= 1'b0;
      aw_addr    <= 8'h00;
      w_data     <= 32'h0;
      w_strb     <= 4'h0;
      s_bvalid_o <= 1'b0;
      s_bresp_o  <= 2'b00;
    end
    else if (ce_i)
    begin
      if (aw_take)
        aw_addr <= s_awaddr_i;
      if (w_take)
      begin
        w_data <= s_wdata_i;
        w_strb <= s_wstrb_i;
      end
      if (wr_fire)
      begin
        aw_held    <= 1'b0;
        w_held     <= 1'b0;
        s_bvalid_o <= 1'b1;
        s_bresp_o  <= wr_map ? 2'b00 : 2'b10; // slverr on unmapped
      end
      else
      begin
        if (aw_take)
          aw_held <= 1'b1;
        if (w_take)
          w_held <= 1'b1;
        if (s_bvalid_o && s_bready_i)
          s_bvalid_o <= 1'b0;
      end
    end
  end

  // read channel
  // arready drops while rvalid stands, so one read is in flight
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ar_held    <= 1'b0;
      ar_addr    <= 8'h00;
      s_rvalid_o <= 1'b0;
      s_rdata_o  <= 32'h0;
      s_rresp_o  <= 2'b00;
    end
    else if (ce_i)
    begin
      if (ar_take)
      begin
        ar_held <= 1'b1;
        ar_addr <= s_araddr_i;
      end
      if (rd_fire)
      begin
        ar_held    <= 1'b0;
        s_rvalid_o <= 1'b1;
        s_rdata_o  <= rd_word;
        s_rresp_o  <= rd_map ? 2'b00 : 2'b10;
      end
      else if (s_rvalid_o && s_rready_i)
        s_rvalid_o <= 1'b0;
    end
  end
endmodule // acc_top
`default_nettype wire
